// *** panel_params.svh ***
// timing counts, field limits and register offsets of the front panel menu controller
`ifndef PANEL_PARAMS_SVH
`define PANEL_PARAMS_SVH
`define CLK_PERIOD_NS 50
`define TICK_NS 1000000
`define SESSION_IDLE_MS 30000
`define GAIN_IDLE_MS 12000
`define LAMP_TEST_MS 1000
`define VERSION_SHOW_MS 1000
`define DEBOUNCE_MS 10
`define GAIN_MAX 6'h3c
`define GAIN_STEP_FINE 6'h02
`define GAIN_STEP_COARSE 6'h14
`define ADDR_MAX 5'h1f
`define ADDR_STEP_FINE 5'h01
`define ADDR_STEP_COARSE 5'h0a
`define CURSOR_RETURN 2'h2
`define SETTINGS_DEFAULT 16'h0004
`define REF_LABEL_INTERNAL 2'h0
`define REFERENCE_EXTERNAL_LABEL 2'h1
`define REF_LABEL_AUTO_EXT 2'h2
`define REF_LABEL_AUTO_INT 2'h3
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SAVED 8'h08
`define REG_LIVE 8'h0c
`define CTRL_MUTE_BIT 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** panel_pkg.sv ***
// types shared by the front panel menu controller
package panel_pkg;
  typedef enum logic [4:0] {
    ST_LAMP = 5'h01, ST_VERSION = 5'h02, ST_NORMAL = 5'h04, ST_EDIT = 5'h08, ST_SAVE = 5'h10
  } state_e;
  typedef enum logic [2:0] {
    IT_GAIN = 3'h0, IT_REMOTE = 3'h1, IT_IFACE = 3'h2, IT_ADDR = 3'h3, IT_REF = 3'h4,
    IT_INVERT = 3'h5
  } item_e;
  typedef enum logic [1:0] {RM_INT = 2'h0, RM_EXT = 2'h1, RM_AUTO = 2'h2} ref_mode_e;
  typedef struct packed {
    logic [5:0] gain;
    logic remote;
    logic iface;
    logic [4:0] addr;
    ref_mode_e ref_mode;
    logic invert;
  } settings_s;
endpackage

// *** front_panel_menu_control.sv ***
// front panel menu controller: switches, menu sequencing, settings, alarms, axi4-lite registers
`include "panel_params.svh"

module front_panel_menu_control #(
  parameter int unsigned TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS,
  parameter int unsigned SESSION_MS = `SESSION_IDLE_MS,
  parameter int unsigned GAIN_MS = `GAIN_IDLE_MS,
  parameter int unsigned LAMP_MS = `LAMP_TEST_MS,
  parameter int unsigned VERSION_MS = `VERSION_SHOW_MS,
  parameter int unsigned DEBOUNCE_MS = `DEBOUNCE_MS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sw_exec,
  input wire logic sw_left,
  input wire logic sw_right,
  input wire logic sw_up,
  input wire logic sw_down,
  input wire logic [1:0] lo_lock,
  input wire logic ext_level_ok,
  input wire logic [15:0] nv_rdata,
  output logic nv_write,
  output logic [15:0] nv_wdata,
  output logic [5:0] gain_atten,
  output logic remote_mode,
  output logic iface_sel,
  output logic [4:0] serial_addr,
  output logic invert_spectrum,
  output logic ref_sel_ext,
  output logic [1:0] ref_label,
  output logic alarm_out,
  output logic alarm_led,
  output logic remote_led,
  output logic mute_led,
  output logic [4:0] display_state,
  output logic [2:0] menu_item,
  output logic [1:0] cursor_pos,
  output logic save_answer_yes,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int SW_EXEC = 0;
  localparam int SW_LEFT = 1;
  localparam int SW_RIGHT = 2;
  localparam int SW_UP = 3;
  localparam int SW_DOWN = 4;
  localparam logic [14:0] DIV_LAST = 15'(TICK_CYCLES - 1);
  localparam logic [14:0] SES_LAST = 15'(SESSION_MS - 1);
  localparam logic [14:0] GAIN_LAST = 15'(GAIN_MS - 1);
  localparam logic [14:0] LAMP_LAST = 15'(LAMP_MS - 1);
  localparam logic [14:0] VER_LAST = 15'(VERSION_MS - 1);
  localparam logic [3:0] DB_LAST = 4'(DEBOUNCE_MS - 1);

  typedef struct packed {
    panel_pkg::state_e st;
    panel_pkg::item_e item;
    logic [1:0] cur;
    logic yes;
    panel_pkg::settings_s live;
    panel_pkg::settings_s saved;
    logic loaded;
    logic nv_write;
    logic [14:0] div;
    logic tick;
    logic [14:0] tm;
    logic [4:0] sw_db;
    logic [4:0][3:0] db_cnt;
    logic [4:0] ev;
    logic mute;
    logic alarm;
    logic reference_external_label;
    logic [1:0] ref_label;
    logic awready;
    logic wready;
    logic [7:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctl_s;

  ctl_s q;
  ctl_s next_q;
  logic [4:0] raw;
  logic timeout_hit;
  logic [5:0] gstep;
  logic [4:0] astep;

  assign raw = {sw_down, sw_up, sw_right, sw_left, sw_exec};
  assign timeout_hit = (q.tm == SES_LAST) || (q.item == panel_pkg::IT_GAIN && q.tm == GAIN_LAST);
  assign gstep = (q.cur == 2'h0) ? `GAIN_STEP_COARSE : `GAIN_STEP_FINE;
  assign astep = (q.cur == 2'h0) ? `ADDR_STEP_COARSE : `ADDR_STEP_FINE;

  always_comb begin
    next_q = q;
    next_q.tick = 1'b0;
    next_q.ev = 5'h00;
    next_q.nv_write = 1'b0;
    // one millisecond enable paces debounce and every panel timer
    if (q.div == DIV_LAST) begin
      next_q.div = 15'h0000;
      next_q.tick = 1'b1;
    end else begin
      next_q.div = q.div + 15'h0001;
    end
    for (int i = 0; i < 5; i++) begin
      if (q.tick) begin
        if (raw[i] == q.sw_db[i]) begin
          next_q.db_cnt[i] = 4'h0;
        end else if (q.db_cnt[i] == DB_LAST) begin
          next_q.sw_db[i] = raw[i];
          next_q.db_cnt[i] = 4'h0;
          next_q.ev[i] = raw[i];
        end else begin
          next_q.db_cnt[i] = q.db_cnt[i] + 4'h1;
        end
      end
    end
    // idle timer restarts on any actuation and on every state change
    if (|q.ev) begin
      next_q.tm = 15'h0000;
    end else if (q.tick && q.tm != 15'h7fff) begin
      next_q.tm = q.tm + 15'h0001;
    end

    unique case (q.st)
      panel_pkg::ST_LAMP: begin
        if (!q.loaded) begin
          next_q.loaded = 1'b1;
          next_q.live = panel_pkg::settings_s'(nv_rdata);
          next_q.saved = panel_pkg::settings_s'(nv_rdata);
        end
        if (q.tm == LAMP_LAST) begin
          next_q.st = panel_pkg::ST_VERSION;
          next_q.tm = 15'h0000;
        end
      end
      panel_pkg::ST_VERSION: begin
        if (q.tm == VER_LAST) begin
          next_q.st = panel_pkg::ST_NORMAL;
          next_q.tm = 15'h0000;
        end
      end
      panel_pkg::ST_NORMAL: begin
        if (q.ev[SW_EXEC]) begin
          next_q.st = panel_pkg::ST_EDIT;
          next_q.item = panel_pkg::IT_GAIN;
          next_q.cur = 2'h0;
          next_q.tm = 15'h0000;
        end
      end
      panel_pkg::ST_EDIT: begin
        if (timeout_hit) begin
          next_q.live = q.saved;
          next_q.st = panel_pkg::ST_NORMAL;
          next_q.tm = 15'h0000;
        end else if (q.ev[SW_EXEC]) begin
          next_q.tm = 15'h0000;
          next_q.cur = 2'h0;
          if (q.cur == `CURSOR_RETURN || q.item == panel_pkg::IT_INVERT) begin
            next_q.st = panel_pkg::ST_SAVE;
            next_q.yes = 1'b0;
          end else begin
            next_q.item = panel_pkg::item_e'(q.item + 3'h1);
          end
        end else if (q.ev[SW_LEFT] || q.ev[SW_RIGHT]) begin
          if (q.ev[SW_LEFT] && q.cur != 2'h0) begin
            next_q.cur = q.cur - 2'h1;
          end else if (q.ev[SW_RIGHT] && q.cur != `CURSOR_RETURN) begin
            next_q.cur = q.cur + 2'h1;
          end
        end else if ((q.ev[SW_UP] || q.ev[SW_DOWN]) && q.cur != `CURSOR_RETURN) begin
          unique case (q.item)
            panel_pkg::IT_GAIN: begin
              // gain code is attenuation in half-dB units; edits reach the rf path at once
              if (q.ev[SW_UP]) begin
                next_q.live.gain = (q.live.gain > `GAIN_MAX - gstep) ? `GAIN_MAX
                                   : q.live.gain + gstep;
              end else begin
                next_q.live.gain = (q.live.gain < gstep) ? 6'h00
                                   : q.live.gain - gstep;
              end
            end
            panel_pkg::IT_REMOTE: next_q.live.remote = !q.live.remote;
            panel_pkg::IT_IFACE: next_q.live.iface = !q.live.iface;
            panel_pkg::IT_ADDR: begin
              if (q.ev[SW_UP]) begin
                next_q.live.addr = (q.live.addr > `ADDR_MAX - astep) ? `ADDR_MAX
                                   : q.live.addr + astep;
              end else begin
                next_q.live.addr = (q.live.addr < astep) ? 5'h00
                                   : q.live.addr - astep;
              end
            end
            panel_pkg::IT_REF: begin
              next_q.live.ref_mode = (q.live.ref_mode == panel_pkg::RM_INT) ? panel_pkg::RM_EXT
                                   : (q.live.ref_mode == panel_pkg::RM_EXT) ? panel_pkg::RM_AUTO
                                   : panel_pkg::RM_INT;
            end
            panel_pkg::IT_INVERT: next_q.live.invert = !q.live.invert;
            default: next_q.item = panel_pkg::IT_GAIN;
          endcase
        end
      end
      panel_pkg::ST_SAVE: begin
        if (q.tm == SES_LAST) begin
          next_q.live = q.saved;
          next_q.st = panel_pkg::ST_NORMAL;
          next_q.tm = 15'h0000;
        end else if (q.ev[SW_EXEC]) begin
          next_q.st = panel_pkg::ST_NORMAL;
          next_q.tm = 15'h0000;
          if (q.yes) begin
            next_q.saved = q.live;
            next_q.nv_write = 1'b1;
          end else begin
            next_q.live = q.saved;
          end
        end else if (q.ev[SW_UP] || q.ev[SW_DOWN]) begin
          next_q.yes = !q.yes;
        end
      end
      default: next_q.st = panel_pkg::ST_NORMAL;
    endcase

    next_q.alarm = (lo_lock != 2'h3);
    // an undefined stored mode code behaves as internal
    next_q.reference_external_label = (q.live.ref_mode == panel_pkg::RM_EXT)
                     || (q.live.ref_mode == panel_pkg::RM_AUTO && ext_level_ok);
    if (q.live.ref_mode == panel_pkg::RM_EXT) begin
      next_q.ref_label = `REFERENCE_EXTERNAL_LABEL;
    end else if (q.live.ref_mode == panel_pkg::RM_AUTO) begin
      next_q.ref_label = ext_level_ok ? `REF_LABEL_AUTO_EXT : `REF_LABEL_AUTO_INT;
    end else begin
      next_q.ref_label = `REF_LABEL_INTERNAL;
    end

    // write channel: address and data held independently, answered once both are in
    if (q.awready && s_axi_awvalid) begin
      next_q.awready = 1'b0;
      next_q.waddr = s_axi_awaddr;
    end
    if (q.wready && s_axi_wvalid) begin
      next_q.wready = 1'b0;
      next_q.wdat = s_axi_wdata;
      next_q.wstb = s_axi_wstrb;
    end
    if (!q.awready && !q.wready && !q.bvalid) begin
      next_q.bvalid = 1'b1;
      if (q.waddr == `REG_CTRL) begin
        next_q.bresp = `RESP_OKAY;
        if (q.wstb[0]) begin
          next_q.mute = q.wdat[`CTRL_MUTE_BIT];
        end
      end else begin
        next_q.bresp = `RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
      next_q.awready = 1'b1;
      next_q.wready = 1'b1;
    end
    if (q.arready && s_axi_arvalid) begin
      next_q.arready = 1'b0;
      next_q.rvalid = 1'b1;
      next_q.rresp = `RESP_OKAY;
      unique case (s_axi_araddr)
        `REG_CTRL: next_q.rdata = {31'h00000000, q.mute};
        `REG_STATUS: next_q.rdata = {19'h00000, q.reference_external_label, q.alarm, q.yes, q.cur, q.item, q.st};
        `REG_SAVED: next_q.rdata = {16'h0000, q.saved};
        `REG_LIVE: next_q.rdata = {16'h0000, q.live};
        default: begin
          next_q.rdata = 32'h00000000;
          next_q.rresp = `RESP_SLVERR;
        end
      endcase
    end
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
      next_q.arready = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '0;
      q.st <= panel_pkg::ST_LAMP;
      q.live <= `SETTINGS_DEFAULT;
      q.saved <= `SETTINGS_DEFAULT;
      q.alarm <= 1'b1;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign nv_write = q.nv_write;
  assign nv_wdata = q.saved;
  assign gain_atten = q.live.gain;
  assign remote_mode = q.live.remote;
  assign iface_sel = q.live.iface;
  assign serial_addr = q.live.addr;
  assign invert_spectrum = q.live.invert;
  assign ref_sel_ext = q.reference_external_label;
  assign ref_label = q.ref_label;
  assign alarm_out = q.alarm;
  assign alarm_led = q.alarm;
  assign remote_led = q.live.remote;
  assign mute_led = q.mute;
  assign display_state = q.st;
  assign menu_item = q.item;
  assign cursor_pos = q.cur;
  assign save_answer_yes = q.yes;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  // checks
  logic commit_req;
  logic edit_go;
  logic horiz;
  assign commit_req = q.st == panel_pkg::ST_SAVE && q.ev[SW_EXEC] && q.yes && q.tm != SES_LAST;
  assign edit_go = q.st == panel_pkg::ST_EDIT && !timeout_hit && !q.ev[SW_EXEC];
  assign horiz = q.ev[SW_LEFT] || q.ev[SW_RIGHT];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_alarm_follow: assert property ((lo_lock != 2'h3) |=> alarm_out && alarm_led)
    else $error("alarm not raised on lost lock");
  a_commit_only: assert property (nv_write |-> $past(commit_req))
    else $error("settings stored without confirmed save");
  a_no_restores: assert property ((q.st == panel_pkg::ST_SAVE && q.ev[SW_EXEC] && !q.yes
    && q.tm != SES_LAST) |=> q.live == q.saved && !nv_write)
    else $error("no answer did not restore settings");
  a_session_drop: assert property ((q.st == panel_pkg::ST_EDIT && q.tm == SES_LAST)
    |=> q.st == panel_pkg::ST_NORMAL && q.live == q.saved)
    else $error("idle session not abandoned");
  a_gain_idle: assert property ((q.st == panel_pkg::ST_EDIT && q.item == panel_pkg::IT_GAIN
    && q.tm == GAIN_LAST) |=> q.st == panel_pkg::ST_NORMAL ##1 !nv_write)
    else $error("gain menu did not time out");
  a_gain_bound: assert property (gain_atten <= `GAIN_MAX)
    else $error("gain out of range");
  a_gain_step: assert property ((edit_go && !horiz && q.item == panel_pkg::IT_GAIN
    && q.cur == 2'h1 && q.ev[SW_UP] && gain_atten <= `GAIN_MAX - `GAIN_STEP_FINE)
    |=> gain_atten == $past(gain_atten) + `GAIN_STEP_FINE)
    else $error("gain step wrong");
  a_cursor_step: assert property ((edit_go && q.ev[SW_RIGHT] && !q.ev[SW_LEFT]
    && q.cur != `CURSOR_RETURN) |=> cursor_pos == $past(cursor_pos) + 2'h1)
    else $error("cursor did not move right");
  a_onoff_toggle: assert property ((edit_go && !horiz && q.item == panel_pkg::IT_REMOTE
    && q.cur != `CURSOR_RETURN && (q.ev[SW_UP] || q.ev[SW_DOWN]))
    |=> remote_mode != $past(remote_mode))
    else $error("on/off item did not toggle");
  a_ref_auto: assert property ((q.live.ref_mode == panel_pkg::RM_AUTO && !ext_level_ok)
    |=> !ref_sel_ext && ref_label == `REF_LABEL_AUTO_INT)
    else $error("weak external reference still selected");
  a_boot_order: assert property ($rose(display_state[1]) |-> $past(display_state[0]))
    else $error("version shown out of order");

  c_commit: cover property (nv_write);
  c_save_no: cover property (q.st == panel_pkg::ST_SAVE && q.ev[SW_EXEC] && !q.yes);
  c_timeout: cover property (q.st == panel_pkg::ST_EDIT && timeout_hit);
endmodule

// *** panel_operator.sv ***
// operator and settings store model facing the front panel switches
module panel_operator #(
  parameter int unsigned HOLD = 16,
  parameter logic [15:0] NV_INIT = 16'h2a2a
) (
  input wire logic sys_clk,
  output logic sw_exec,
  output logic sw_left,
  output logic sw_right,
  output logic sw_up,
  output logic sw_down,
  input wire logic nv_write,
  input wire logic [15:0] nv_wdata,
  output logic [15:0] nv_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] sw = 5'h00;
  logic [15:0] nv_mem = NV_INIT;
  assign {sw_down, sw_up, sw_right, sw_left, sw_exec} = sw;
  assign nv_rdata = nv_mem;
  // contents survive the bench's reset pulses, which stand in for power loss
  always @(posedge sys_clk) begin
    if (nv_write === 1'b1) begin
      nv_mem <= nv_wdata;
    end
  end
  // released for HOLD cycles whatever the hold, so the debounced level drops before the next press
  task actuate(input int idx, input int hold);
    sw[idx] <= 1'b1;
    repeat (hold) @(posedge sys_clk);
    sw[idx] <= 1'b0;
    repeat (HOLD) @(posedge sys_clk);
  endtask
endmodule

// *** front_panel_menu_control_tb.sv ***
// self-checking bench for the front panel menu controller
`include "panel_params.svh"
module front_panel_menu_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 4;
  localparam logic [4:0] NRM = panel_pkg::ST_NORMAL;
  localparam logic [4:0] EDT = panel_pkg::ST_EDIT;
  localparam logic [4:0] SAV = panel_pkg::ST_SAVE;
  typedef struct packed {logic [1:0] lock; logic ok; logic alarm; logic [1:0] label;} row_s;
  row_s rows [4] = '{'{2'h3, 1'b1, 1'b0, 2'h1}, '{2'h2, 1'b0, 1'b1, 2'h1},
                     '{2'h1, 1'b1, 1'b1, 2'h1}, '{2'h0, 1'b0, 1'b1, 2'h1}};
  logic sys_clk, reset, sw_exec, sw_left, sw_right, sw_up, sw_down, ext_level_ok, nv_write;
  logic [1:0] lo_lock, ref_label, cursor_pos, s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] nv_rdata, nv_wdata;
  logic [5:0] gain_atten;
  logic remote_mode, iface_sel, invert_spectrum, ref_sel_ext, alarm_out, alarm_led;
  logic remote_led, mute_led, save_answer_yes;
  logic [4:0] serial_addr, display_state;
  logic [2:0] menu_item;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_fail = 0;
  int num_checks = 0;
  int n_store = 0;
  int cyc;

  front_panel_menu_control #(.TICK_CYCLES(TK), .SESSION_MS(40), .GAIN_MS(20), .LAMP_MS(3),
    .VERSION_MS(3), .DEBOUNCE_MS(2)) u_dut (
    .sys_clk, .reset, .sw_exec, .sw_left, .sw_right, .sw_up, .sw_down, .lo_lock,
    .ext_level_ok, .nv_rdata, .nv_write, .nv_wdata, .gain_atten, .remote_mode, .iface_sel,
    .serial_addr, .invert_spectrum, .ref_sel_ext, .ref_label, .alarm_out, .alarm_led,
    .remote_led, .mute_led, .display_state, .menu_item, .cursor_pos, .save_answer_yes,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  panel_operator u_op (.sys_clk, .sw_exec, .sw_left, .sw_right, .sw_up, .sw_down, .nv_write,
    .nv_wdata, .nv_rdata);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (nv_write === 1'b1) n_store++;
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task give_up();
    n_fail++;
    $display("[ERR] t=%0t wait ran out", $time);
    end_of_test();
  endtask

  task cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // 0 exec, 1 left, 2 right, 3 up, 4 down
  task p(input int idx);
    u_op.actuate(idx, 16);
  endtask

  task wait_state(input logic [4:0] s, input int lim);
    cyc = 0;
    while (display_state !== s) begin
      @(posedge sys_clk);
      cyc++;
      if (cyc > lim) give_up();
    end
  endtask

  task axi_write(input logic [7:0] a, input logic [31:0] d);
    cyc = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      cyc++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && cyc < 40);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (cyc >= 40) give_up();
  endtask

  task axi_read(input logic [7:0] a);
    cyc = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      cyc++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && cyc < 40);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (cyc >= 40) give_up();
  endtask

  initial begin
    reset = 1'b1;
    lo_lock = 2'h3;
    ext_level_ok = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    cycles(16);
    reset <= 1'b0;
    cycles(3);
    check(display_state, panel_pkg::ST_LAMP);
    check(gain_atten, 6'h0a);
    check(serial_addr, 5'h05);
    check(remote_led, 1'b1);
    wait_state(panel_pkg::ST_VERSION, 3 * TK + 10);
    wait_state(NRM, 3 * TK + 10);
    $display("test power_up done");
    foreach (rows[i]) begin
      lo_lock <= rows[i].lock;
      ext_level_ok <= rows[i].ok;
      cycles(3);
      check(alarm_out, rows[i].alarm);
      check(alarm_led, rows[i].alarm);
      check(ref_label, rows[i].label);
      check(ref_sel_ext, 1'b1);
    end
    lo_lock <= 2'h3;
    ext_level_ok <= 1'b1;
    $display("test table done");
    u_op.actuate(0, 2);
    check(display_state, NRM);
    p(0);
    check(display_state, EDT);
    check(cursor_pos, 2'h0);
    p(3);
    check(gain_atten, 6'h1e);
    p(2);
    check(cursor_pos, 2'h1);
    p(3);
    check(gain_atten, 6'h20);
    p(1);
    repeat (2) p(4);
    check(gain_atten, 6'h00);
    repeat (4) p(3);
    check(gain_atten, `GAIN_MAX);
    for (int i = 1; i < 6; i++) begin
      p(0);
      check(menu_item, i[2:0]);
      if (i == 1) begin
        p(3);
        check(remote_led, 1'b0);
        p(4);
        check(remote_mode, 1'b1);
      end
      if (i == 2) begin
        p(3);
        check(iface_sel, 1'b1);
      end
      if (i == 3) begin
        p(3);
        check(serial_addr, 5'h0f);
      end
      if (i == 5) begin
        p(4);
        check(invert_spectrum, 1'b1);
      end
      if (i == 4) begin
        p(3);
        check(ref_label, `REF_LABEL_AUTO_EXT);
        ext_level_ok <= 1'b0;
        cycles(3);
        check(ref_label, `REF_LABEL_AUTO_INT);
        check(ref_sel_ext, 1'b0);
        ext_level_ok <= 1'b1;
        p(4);
        check(ref_label, `REF_LABEL_INTERNAL);
      end
    end
    p(0);
    check(display_state, SAV);
    check(save_answer_yes, 1'b0);
    p(3);
    p(0);
    wait_state(NRM, 20);
    check(n_store, 1);
    check(nv_wdata, 16'hf379);
    axi_read(`REG_SAVED);
    check(rd, 32'h0000f379);
    $display("test save done");
    p(0);
    p(4);
    check(gain_atten, 6'h28);
    repeat (2) p(2);
    p(3);
    check(gain_atten, 6'h28);
    p(0);
    check(display_state, SAV);
    p(0);
    wait_state(NRM, 20);
    check(gain_atten, `GAIN_MAX);
    p(0);
    p(4);
    wait_state(NRM, 30 * TK);
    check(gain_atten, `GAIN_MAX);
    p(0);
    p(0);
    p(3);
    cycles(20 * TK);
    check(display_state, EDT);
    wait_state(NRM, 30 * TK);
    check(remote_mode, 1'b1);
    check(n_store, 1);
    $display("test discard done");
    axi_write(`REG_CTRL, 32'h1);
    check(resp, `RESP_OKAY);
    cycles(2);
    check(mute_led, 1'b1);
    axi_write(`REG_STATUS, 32'hffff);
    check(resp, `RESP_SLVERR);
    axi_read(8'h20);
    check(resp, `RESP_SLVERR);
    check(rd, 32'h0);
    axi_read(`REG_LIVE);
    check(rd, 32'h0000f379);
    axi_write(`REG_CTRL, 32'h0);
    cycles(2);
    check(mute_led, 1'b0);
    reset <= 1'b1;
    cycles(16);
    reset <= 1'b0;
    cycles(3);
    check(gain_atten, `GAIN_MAX);
    check(ref_label, `REF_LABEL_INTERNAL);
    $display("test power_cycle done");
    end_of_test();
  end
endmodule
